// ===== design/fsa_pkg.sv
// Shared constants and carriers for the serial flash command block
package fsa_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
  localparam logic [7:0] OP_WR_SR1 = 8'h01;
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  localparam logic [7:0] OP_WR_SR3 = 8'h11;
  localparam logic [7:0] OP_RD_SR1 = 8'h05;
  localparam logic [7:0] OP_RD_SR2 = 8'h35;
  localparam logic [7:0] OP_RD_SR3 = 8'h15;
  localparam logic [7:0] OP_RD_UPPER = 8'hC8;
  localparam logic [7:0] OP_WR_UPPER = 8'hC5;
  localparam logic [7:0] OP_ENTER_4B = 8'hB7;
  localparam logic [7:0] OP_EXIT_4B = 8'hE9;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_4B = 8'h13;

  // ----------------------------------------------------------------
  // Status field layout and write masks
  // ----------------------------------------------------------------
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int SRL_BIT = 0;
  localparam int QE_BIT = 1;
  localparam int LB_LSB = 3;
  localparam int LB_MSB = 5;
  localparam int ADS_BIT = 0;
  localparam int ADP_BIT = 1;
  localparam logic [7:0] SR1_WR_MASK = 8'hFC;
  localparam logic [7:0] SR2_WR_MASK = 8'h7B;
  localparam logic [7:0] SR3_WR_MASK = 8'hE6;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [7:0] UPPER_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTES_3B = 4'h4;
  localparam logic [3:0] BYTES_4B = 4'h5;
  localparam logic [3:0] BYTES_MAX = 4'hF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int STATUS_WRITE_CYCLE_TIME_US = 10000;
  localparam int VOLATILE_REFRESH_TIME_NS = 50;
  localparam int TW_CYCLES =
    (STATUS_WRITE_CYCLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLES =
    (VOLATILE_REFRESH_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
    VOLATILE_REFRESH_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] upper;
  } fsa_view_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [1:0] fl_sync;
    logic seq_done;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] st3;
    logic [7:0] nv1;
    logic [7:0] nv2;
    logic [7:0] nv3;
    logic [7:0] pd1;
    logic [7:0] pd2;
    logic [7:0] pd3;
    logic write_enable_latch;
    logic vol_en;
    logic busy;
    logic vol_wr;
    logic [2:0] nv_sel;
    logic [31:0] tmr;
    logic [7:0] upper;
    logic address_mode_flag;
    fsa_view_t view;
  } fsa_core_t;

  typedef struct packed {
    logic seq;
    logic [7:0] op;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [3:0] nb;
    fsa_view_t v1;
    fsa_view_t v2;
    logic fl1;
    logic fl2;
  } fsa_cmd_t;

  typedef struct packed {
    logic [2:0] bi;
    logic [3:0] nb;
    logic [7:0] sh;
    logic [31:0] addr;
    logic [31:0] rd_addr;
    logic reading;
  } fsa_frame_t;

  typedef struct packed {
    logic so;
    logic oe;
    logic [7:0] sh;
  } fsa_tx_t;

endpackage

// ===== design/fsa_cmd.sv
// Status, upper address and single-line read command handling
`timescale 1ns/1ns

// Functional notes
// - 01h/31h/11h write status 1/2/3; only writable bits change.
// - One-time lock bits stay set until hardware reset; soft reset keeps only those in stored status.
// - Non-volatile status write needs write enable latch set by 06h.
// - Volatile status write follows 50h; write enable latch stays untouched.
// - Volatile path cannot clear status lock or one-time lock bits.
// - Software reset reloads volatile status from stored values; hardware reset zeroes both.
// - Non-volatile write runs a timed cycle with busy set; status reads still work.
// - Write enable latch clears when the non-volatile cycle ends.
// - Volatile write lands within refresh time; busy stays zero.
// - Status write in both modes; four-line mode keeps quad enable.
// - All status bits are zero by default.
// - 01h with sixteen bits writes status 1 and 2; eight bits only 1.
// - C8h returns upper address byte, MSB first, on falling edges.
// - Three-byte mode takes address bits 31..24 from upper byte.
// - C5h plus a byte loads upper byte only with latch set.
// - Upper address byte is volatile and clears on any reset.
// - Four-byte mode: commands with address top byte overwrite upper byte.
// - B7h enters 32-bit addressing, E9h returns to 24-bit addressing.
// - 03h reads with 24/32-bit address, streaming, one-line mode only.
// - 13h reads like 03h but always with 32-bit address.
// - Reads arriving while busy are ignored without disturbing the cycle.
// - 06h sets the write enable latch.
module fsa_cmd
  import fsa_pkg::*;
#(
  parameter int TW_CYC = TW_CYCLES
) (
  // System side
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_soft_reset,
  // Serial link
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_serial_in_line,
  input wire logic i_four_line_command_mode,
  output logic o_so,
  output logic o_so_oe,
  // Array access (serial clock domain)
  input wire logic [7:0] i_rd_data,
  output logic [31:0] o_rd_addr,
  output logic o_rd_active,
  // Device state
  output logic o_busy,
  output logic o_address_mode_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] fsa_merge(input logic [7:0] old,
                                           input logic [7:0] wr,
                                           input logic [7:0] mask);
    fsa_merge = (old & ~mask) | (wr & mask);
  endfunction

  function automatic logic [7:0] fsa_sr2(input logic [7:0] old,
                                         input logic [7:0] wr,
                                         input logic vol,
                                         input logic quad);
    logic [7:0] v;
    v = fsa_merge(old, wr, SR2_WR_MASK);
    v[LB_MSB:LB_LSB] = v[LB_MSB:LB_LSB] | old[LB_MSB:LB_LSB];
    if (vol) begin
      v[SRL_BIT] = v[SRL_BIT] | old[SRL_BIT];
    end
    if (quad) begin
      v[QE_BIT] = old[QE_BIT];
    end
    fsa_sr2 = v;
  endfunction

  // ----------------------------------------------------------------
  // Serial clock domain
  // ----------------------------------------------------------------
  fsa_cmd_t cmd_r;
  fsa_cmd_t cmd_nxt;
  fsa_frame_t fr_r;
  fsa_frame_t fr_nxt;
  fsa_tx_t tx_r;
  fsa_tx_t tx_nxt;
  fsa_core_t c_r;
  fsa_core_t c_nxt;
  logic frame_rst;
  logic [7:0] inb;
  logic [3:0] nb_inc;
  logic is_read;
  logic addr4;
  logic [7:0] src;
  logic talk;

  // Frame logic ends with the frame's own select, so a stopped clock
  // between frames cannot leave stale counters behind.
  assign frame_rst = i_cs_n | ~i_resetn;

  always_comb begin
    cmd_nxt = cmd_r;
    fr_nxt = fr_r;
    cmd_nxt.v1 = c_r.view;
    cmd_nxt.v2 = cmd_r.v1;
    cmd_nxt.fl1 = i_four_line_command_mode;
    cmd_nxt.fl2 = cmd_r.fl1;
    inb = {fr_r.sh[6:0], i_serial_in_line};
    nb_inc = (fr_r.nb == BYTES_MAX) ? fr_r.nb : fr_r.nb + 4'h1;
    is_read = (cmd_r.op == OP_READ) || (cmd_r.op == OP_READ_4B);
    addr4 = (cmd_r.op == OP_READ_4B) || cmd_r.v2.s3[ADS_BIT];
    fr_nxt.bi = fr_r.bi + 3'h1;
    fr_nxt.sh = inb;
    if (fr_r.bi == 3'h0 && fr_r.nb == 4'h0) begin
      cmd_nxt.seq = ~cmd_r.seq;
      cmd_nxt.nb = 4'h0;
    end
    if (fr_r.nb != 4'h0 && is_read && !fr_r.reading) begin
      fr_nxt.addr = {fr_r.addr[30:0], i_serial_in_line};
    end
    if (fr_r.bi == 3'h7) begin
      fr_nxt.nb = nb_inc;
      cmd_nxt.nb = nb_inc;
      unique case (fr_r.nb)
        4'h0: cmd_nxt.op = inb;
        4'h1: cmd_nxt.d1 = inb;
        4'h2: cmd_nxt.d2 = inb;
        default: ;
      endcase
      if (fr_r.reading) begin
        fr_nxt.rd_addr = fr_r.rd_addr + 32'h1;
      end else if (is_read &&
                   nb_inc == (addr4 ? BYTES_4B : BYTES_3B) &&
                   !cmd_r.v2.s1[BUSY_BIT] &&
                   !cmd_r.fl2) begin
        fr_nxt.reading = 1'b1;
        if (addr4) begin
          fr_nxt.rd_addr = {fr_r.addr[30:0], i_serial_in_line};
        end else begin
          fr_nxt.rd_addr = {cmd_r.v2.upper,
                            fr_r.addr[22:0], i_serial_in_line};
        end
      end
    end
  end

  always_ff @(posedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  always_ff @(posedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      fr_r <= '0;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // Falling-edge shifter for the data-out line
  always_comb begin
    tx_nxt = tx_r;
    unique case (cmd_r.op)
      OP_RD_SR1: src = cmd_r.v2.s1;
      OP_RD_SR2: src = cmd_r.v2.s2;
      OP_RD_SR3: src = cmd_r.v2.s3;
      OP_RD_UPPER: src = cmd_r.v2.upper;
      default: src = i_rd_data;
    endcase
    talk = fr_r.reading ||
           (fr_r.nb != 4'h0 && !is_read &&
            (cmd_r.op == OP_RD_SR1 || cmd_r.op == OP_RD_SR2 ||
             cmd_r.op == OP_RD_SR3 || cmd_r.op == OP_RD_UPPER));
    tx_nxt.oe = talk;
    if (!talk) begin
      tx_nxt.so = 1'b0;
      tx_nxt.sh = 8'h00;
    end else if (fr_r.bi == 3'h0) begin
      tx_nxt.so = src[7];
      tx_nxt.sh = {src[6:0], 1'b0};
    end else begin
      tx_nxt.so = tx_r.sh[7];
      tx_nxt.sh = {tx_r.sh[6:0], 1'b0};
    end
  end

  always_ff @(negedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      tx_r <= '0;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  assign o_so = tx_r.so;
  assign o_so_oe = tx_r.oe;
  assign o_rd_addr = fr_r.rd_addr;
  assign o_rd_active = fr_r.reading;

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  logic cs_rise;
  logic go;
  logic quad;
  logic [3:0] nb;
  logic wr_op;

  // Command bytes are read only after the synced select has risen, when
  // the serial clock is idle and they stand still.
  always_comb begin
    c_nxt = c_r;
    c_nxt.cs_sync = {c_r.cs_sync[1:0], i_cs_n};
    c_nxt.fl_sync = {c_r.fl_sync[0], i_four_line_command_mode};
    cs_rise = c_r.cs_sync[1] & ~c_r.cs_sync[2];
    go = cs_rise && (cmd_r.seq != c_r.seq_done);
    quad = c_r.fl_sync[1];
    nb = cmd_r.nb;
    wr_op = (cmd_r.op == OP_WR_SR1) || (cmd_r.op == OP_WR_SR2) ||
            (cmd_r.op == OP_WR_SR3);
    if (go) begin
      c_nxt.seq_done = cmd_r.seq;
    end
    if (c_r.busy) begin
      c_nxt.tmr = c_r.tmr + 32'h1;
      if (c_r.tmr == 32'(TW_CYC - 1)) begin
        c_nxt.busy = 1'b0;
        c_nxt.write_enable_latch = 1'b0;
        // Registers the frame did not name keep their live values
        c_nxt.nv1 = c_r.nv_sel[0] ? c_r.pd1 : c_r.nv1;
        c_nxt.nv2 = c_r.nv_sel[1] ? c_r.pd2 : c_r.nv2;
        c_nxt.nv3 = c_r.nv_sel[2] ? c_r.pd3 : c_r.nv3;
        c_nxt.st1 = c_r.nv_sel[0] ? c_r.pd1 : c_r.st1;
        c_nxt.st2 = c_r.nv_sel[1] ? c_r.pd2 : c_r.st2;
        c_nxt.st3 = c_r.nv_sel[2] ? c_r.pd3 : c_r.st3;
      end
    end else if (c_r.vol_wr) begin
      c_nxt.tmr = c_r.tmr + 32'h1;
      if (c_r.tmr == 32'(REFRESH_CYCLES - 1)) begin
        c_nxt.vol_wr = 1'b0;
        c_nxt.st1 = c_r.pd1;
        c_nxt.st2 = c_r.pd2;
        c_nxt.st3 = c_r.pd3;
      end
    end else if (go && nb != 4'h0) begin
      c_nxt.vol_en = 1'b0;
      unique case (cmd_r.op)
        OP_WR_ENABLE: c_nxt.write_enable_latch = 1'b1;
        OP_WR_DISABLE: c_nxt.write_enable_latch = 1'b0;
        OP_VOL_ENABLE: c_nxt.vol_en = 1'b1;
        OP_ENTER_4B: c_nxt.address_mode_flag = 1'b1;
        OP_EXIT_4B: c_nxt.address_mode_flag = 1'b0;
        OP_WR_UPPER: begin
          if (nb >= 4'h2 && c_r.write_enable_latch) begin
            c_nxt.upper = cmd_r.d1;
          end
        end
        OP_READ, OP_READ_4B: begin
          if (nb >= 4'h2 && c_r.address_mode_flag && !quad) begin
            c_nxt.upper = cmd_r.d1;
          end
        end
        default: ;
      endcase
      if (wr_op && nb >= 4'h2 && (c_r.vol_en || c_r.write_enable_latch)) begin
        // Volatile path merges onto live bits, stored path onto stored
        c_nxt.pd1 = c_r.vol_en ? c_r.st1 : c_r.nv1;
        c_nxt.pd2 = c_r.vol_en ? c_r.st2 : c_r.nv2;
        c_nxt.pd3 = c_r.vol_en ? c_r.st3 : c_r.nv3;
        c_nxt.nv_sel = 3'h0;
        if (cmd_r.op == OP_WR_SR1) begin
          c_nxt.pd1 = fsa_merge(c_nxt.pd1, cmd_r.d1, SR1_WR_MASK);
          c_nxt.nv_sel[0] = 1'b1;
          if (nb >= 4'h3) begin
            c_nxt.pd2 = fsa_sr2(c_nxt.pd2, cmd_r.d2, c_r.vol_en, quad);
            c_nxt.nv_sel[1] = 1'b1;
          end
        end else if (cmd_r.op == OP_WR_SR2) begin
          c_nxt.pd2 = fsa_sr2(c_nxt.pd2, cmd_r.d1, c_r.vol_en, quad);
          c_nxt.nv_sel[1] = 1'b1;
        end else begin
          c_nxt.pd3 = fsa_merge(c_nxt.pd3, cmd_r.d1, SR3_WR_MASK);
          c_nxt.nv_sel[2] = 1'b1;
        end
        // Lock bits set on the volatile path survive a stored write
        c_nxt.pd2[LB_MSB:LB_LSB] = c_nxt.pd2[LB_MSB:LB_LSB] |
                                   c_r.st2[LB_MSB:LB_LSB];
        c_nxt.tmr = 32'h0;
        if (c_r.vol_en) begin
          c_nxt.vol_wr = 1'b1;
        end else begin
          c_nxt.busy = 1'b1;
        end
      end
    end
    if (i_soft_reset) begin
      c_nxt.st1 = c_r.nv1;
      c_nxt.st2 = c_r.nv2;
      c_nxt.st3 = c_r.nv3;
      c_nxt.upper = UPPER_RESET;
      c_nxt.address_mode_flag = c_r.nv3[ADP_BIT];
      c_nxt.write_enable_latch = 1'b0;
      c_nxt.vol_en = 1'b0;
      c_nxt.vol_wr = 1'b0;
      c_nxt.busy = 1'b0;
    end
    c_nxt.view.s1 = {c_nxt.st1[7:2], c_nxt.write_enable_latch, c_nxt.busy};
    c_nxt.view.s2 = c_nxt.st2;
    c_nxt.view.s3 = {c_nxt.st3[7:1], c_nxt.address_mode_flag};
    c_nxt.view.upper = c_nxt.upper;
  end

  // Power-up: every status bit and the upper byte start at zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c_r <= '0;
      c_r.cs_sync <= 3'h7;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign o_busy = c_r.busy;
  assign o_address_mode_flag = c_r.address_mode_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  otp_sticky_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ((c_r.st2[LB_MSB:LB_LSB] & $past(c_r.st2[LB_MSB:LB_LSB])) ==
     $past(c_r.st2[LB_MSB:LB_LSB])))
    else $error("one-time lock bit cleared");

  wel_needed_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(c_r.busy) |-> $past(c_r.write_enable_latch))
    else $error("stored status write without latch");

  vol_keeps_wel_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ($rose(c_r.vol_wr) && !$past(c_r.write_enable_latch)) |-> !c_r.write_enable_latch)
    else $error("volatile path raised latch");

  busy_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn || i_soft_reset)
    $rose(c_r.busy) |-> c_r.busy [*8])
    else $error("write cycle too short");

  wel_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $fell(c_r.busy) |-> !c_r.write_enable_latch)
    else $error("latch not cleared after cycle");

  vol_refresh_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn || i_soft_reset)
    $rose(c_r.vol_wr) |-> !c_r.busy ##[1:2] (!c_r.vol_wr && !c_r.busy))
    else $error("volatile refresh late or busy");

  qe_locked_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (c_r.fl_sync[1] && $past(c_r.fl_sync[1]) && !$past(i_soft_reset))
    |-> $stable(c_r.st2[QE_BIT]))
    else $error("quad enable changed in four-line mode");

  upper_reset_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_soft_reset |=> (c_r.upper == UPPER_RESET))
    else $error("upper byte survived reset");

  read_idle_a: assert property (
    @(posedge i_sck) disable iff (frame_rst)
    $rose(fr_r.reading) |-> !$past(cmd_r.v2.s1[BUSY_BIT]))
    else $error("read started while busy");

  nv_write_c: cover property (
    @(posedge i_clk) disable iff (!i_resetn) $fell(c_r.busy));
  vol_write_c: cover property (
    @(posedge i_clk) disable iff (!i_resetn) $fell(c_r.vol_wr));
  read_burst_c: cover property (
    @(posedge i_sck) disable iff (frame_rst)
    fr_r.reading && fr_r.rd_addr != $past(fr_r.rd_addr));

endmodule

// ===== tb/fsa_host.sv
// Host-side serial controller model that drives the flash link
`timescale 1ns/1ns
module fsa_host (
  // Link outputs
  output logic o_sck,
  output logic o_cs_n,
  output logic o_sdi,
  // Link inputs
  input wire logic i_so,
  input wire logic i_so_oe
);
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int HALF = 6;
  logic oe_seen;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    oe_seen = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame: nb bytes sent from the top of tx, then nr bytes read
  // ----------------------------------------------------------------
  // Clock idles low between frames; data in changes while it is low
  task automatic frame(input logic [47:0] tx, input int nb,
                       input int nr, output logic [15:0] rx);
    rx = 16'h0000;
    oe_seen = 1'b0;
    o_cs_n = 1'b0;
    for (int i = 0; i < nb * 8 + nr * 8; i++) begin
      // Read phase wiggles the input so a stale level never helps
      o_sdi = (i < nb * 8) ? tx[47 - i] : ~o_sdi;
      #HALF o_sck = 1'b1;
      if (i >= nb * 8) begin
        rx = {rx[14:0], i_so};
        oe_seen = oe_seen | i_so_oe;
      end
      #HALF o_sck = 1'b0;
    end
    #HALF o_cs_n = 1'b1;
    // Released line must not keep showing the last bit
    o_sdi = ~o_sdi;
    // Gap covers the select sync and the volatile refresh
    #500;
  endtask
endmodule

// ===== tb/fsa_cmd_tb.sv
// Self-checking bench for the serial flash command block
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module fsa_cmd_tb;
  import fsa_pkg::*;
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] wop;
    logic [15:0] dat;
    logic [1:0] nb;
    logic qm;
    logic [7:0] rop;
    logic [7:0] ex;
  } fsa_row_t;
  logic i_clk;
  logic i_resetn;
  logic i_soft_reset;
  logic sck;
  logic cs_n;
  logic sdi;
  logic qm;
  logic so;
  logic so_oe;
  logic [31:0] rd_addr;
  logic rd_active;
  logic [7:0] rd_data;
  logic o_busy;
  logic mode4;
  logic [15:0] rx;
  logic act_seen;
  int fail_count;
  int n_compared;
  fsa_row_t r;
  // Status paths from a cleared part onwards
  fsa_row_t rows [14] = '{
    '{8'h00, 8'h00, 16'h0000, 2'h0, 1'b0, 8'h05, 8'h00},
    '{8'h00, 8'h00, 16'h0000, 2'h0, 1'b0, 8'h35, 8'h00},
    '{8'h00, 8'h00, 16'h0000, 2'h0, 1'b0, 8'h15, 8'h00},
    '{8'h00, 8'h00, 16'h0000, 2'h0, 1'b0, 8'hC8, 8'h00},
    '{8'h06, 8'h01, 16'hFF00, 2'h1, 1'b0, 8'h05, 8'hFC},
    '{8'h50, 8'h31, 16'hFF00, 2'h1, 1'b0, 8'h35, 8'h7B},
    '{8'h50, 8'h31, 16'h0000, 2'h1, 1'b0, 8'h35, 8'h39},
    '{8'h06, 8'h11, 16'hFD00, 2'h1, 1'b0, 8'h15, 8'hE4},
    '{8'h00, 8'h01, 16'h0000, 2'h1, 1'b0, 8'h05, 8'hFC},
    '{8'h06, 8'h01, 16'h0079, 2'h2, 1'b0, 8'h35, 8'h79},
    '{8'h06, 8'h01, 16'h8000, 2'h1, 1'b0, 8'h35, 8'h79},
    '{8'h00, 8'h00, 16'h0000, 2'h0, 1'b0, 8'h05, 8'h80},
    '{8'h06, 8'h31, 16'h7B00, 2'h1, 1'b1, 8'h35, 8'h79},
    '{8'h50, 8'h11, 16'h6400, 2'h1, 1'b0, 8'h15, 8'h64}
  };

  // Combinational array: byte value mixes low and top address bytes
  assign rd_data = rd_addr[7:0] ^ rd_addr[31:24];

  // Notes any streaming read seen since the flag was last cleared
  always @(posedge rd_active) act_seen = 1'b1;

  fsa_host u_host (
    .o_sck(sck),
    .o_cs_n(cs_n),
    .o_sdi(sdi),
    .i_so(so),
    .i_so_oe(so_oe)
  );

  fsa_cmd #(.TW_CYC(60)) DUT (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_soft_reset(i_soft_reset),
    .i_sck(sck),
    .i_cs_n(cs_n),
    .i_serial_in_line(sdi),
    .i_four_line_command_mode(qm),
    .o_so(so),
    .o_so_oe(so_oe),
    .i_rd_data(rd_data),
    .o_rd_addr(rd_addr),
    .o_rd_active(rd_active),
    .o_busy(o_busy),
    .o_address_mode_flag(mode4)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hx(input logic [47:0] tx, input int nb, input int nr);
    u_host.frame(tx, nb, nr, rx);
  endtask

  // Bounded wait for the timed write cycle to end
  task automatic settle();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 200) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= 200) begin
      fail_count++;
      complete_run();
    end
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    #300000;
    fail_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    n_compared = 0;
    act_seen = 1'b0;
    i_resetn = 1'b0;
    i_soft_reset = 1'b0;
    qm = 1'b0;
    repeat (3) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK("busy after reset", 1'b0, o_busy)
    `CHK("mode after reset", 1'b0, mode4)
    foreach (rows[k]) begin
      r = rows[k];
      @(posedge i_clk);
      #1 qm = r.qm;
      if (r.en !== 8'h00) hx({r.en, 40'h0}, 1, 0);
      if (r.wop !== 8'h00) hx({r.wop, r.dat, 24'h0}, 1 + r.nb, 0);
      settle();
      hx({r.rop, 40'h0}, 1, 1);
      `CHK("row read", r.ex, rx[7:0])
      $display("row %0d done", k);
    end
    @(posedge i_clk);
    #1 qm = 1'b0;
    hx({OP_WR_ENABLE, 40'h0}, 1, 0);
    hx({OP_WR_UPPER, 8'h5A, 32'h0}, 2, 0);
    hx({OP_WR_DISABLE, 40'h0}, 1, 0);
    hx({OP_WR_UPPER, 8'h11, 32'h0}, 2, 0);
    hx({OP_RD_UPPER, 40'h0}, 1, 1);
    `CHK("upper byte", 8'h5A, rx[7:0])
    act_seen = 1'b0;
    hx({OP_READ, 24'h000102, 16'h0}, 4, 2);
    `CHK("read 3 byte", 16'h5859, rx)
    `CHK("read active", 1'b1, act_seen)
    hx({OP_ENTER_4B, 40'h0}, 1, 0);
    `CHK("mode enter", 1'b1, mode4)
    hx({OP_READ, 32'h12345678, 8'h0}, 5, 1);
    `CHK("read 4 byte", 8'h6A, rx[7:0])
    hx({OP_RD_UPPER, 40'h0}, 1, 1);
    `CHK("upper replaced", 8'h12, rx[7:0])
    hx({OP_EXIT_4B, 40'h0}, 1, 0);
    `CHK("mode exit", 1'b0, mode4)
    hx({OP_READ_4B, 32'hA0000010, 8'h0}, 5, 1);
    `CHK("read wide", 8'hB0, rx[7:0])
    hx({OP_RD_UPPER, 40'h0}, 1, 1);
    `CHK("upper kept", 8'h12, rx[7:0])
    hx({OP_READ, 24'h000005, 16'h0}, 4, 1);
    `CHK("read upper", 8'h17, rx[7:0])
    $display("address tests done");
    @(posedge i_clk);
    #1 qm = 1'b1;
    hx({OP_READ, 24'h000005, 16'h0}, 4, 1);
    `CHK("four line read", 1'b0, u_host.oe_seen)
    @(posedge i_clk);
    #1 qm = 1'b0;
    hx({OP_WR_ENABLE, 40'h0}, 1, 0);
    hx({OP_WR_SR1, 8'h80, 32'h0}, 2, 0);
    hx({OP_RD_SR1, 40'h0}, 1, 1);
    `CHK("busy view", 2'h3, rx[1:0])
    act_seen = 1'b0;
    hx({OP_READ, 24'h000005, 16'h0}, 4, 1);
    `CHK("busy read", 1'b0, u_host.oe_seen)
    `CHK("busy held", 1'b1, o_busy)
    `CHK("busy no stream", 1'b0, act_seen)
    settle();
    hx({OP_RD_SR1, 40'h0}, 1, 1);
    `CHK("latch cleared", 8'h80, rx[7:0])
    $display("busy tests done");
    @(posedge i_clk);
    #1 i_soft_reset = 1'b1;
    @(posedge i_clk);
    #1 i_soft_reset = 1'b0;
    repeat (4) @(posedge i_clk);
    hx({OP_RD_SR3, 40'h0}, 1, 1);
    `CHK("reload status", 8'hE4, rx[7:0])
    hx({OP_RD_UPPER, 40'h0}, 1, 1);
    `CHK("upper cleared", 8'h00, rx[7:0])
    $display("soft reset test done");
    complete_run();
  end
endmodule
